// ### design/rps_pkg.sv
// Package with register map, field layout and types of the remappable pin select block.
package rps_pkg;

    localparam int          RPS_NUM_PINS   = 16;
    localparam int          RPS_SEL_W      = 5;
    localparam int          RPS_NUM_IN_SEL = 6;
    localparam int          RPS_NUM_OUT_RG = 8;
    localparam int          RPS_NUM_REGS   = RPS_NUM_IN_SEL / 2 + 1 + RPS_NUM_OUT_RG;
    localparam int          RPS_ADDR_W     = 6;
    localparam int          RPS_REG_W      = 16;
    localparam int          RPS_DATA_W     = 32;
    localparam int          RPS_LO_LSB     = 0;
    localparam int          RPS_HI_LSB     = 8;
    localparam int          RPS_FUNC_W     = RPS_SEL_W;

    // Word indices; byte address is four times the index.
    localparam logic [3:0]  RPS_IDX_FAULT  = 4'h0;
    localparam logic [3:0]  RPS_IDX_UART   = 4'h1;
    localparam logic [3:0]  RPS_IDX_SPICD  = 4'h2;
    localparam logic [3:0]  RPS_IDX_SPISS  = 4'h3;
    localparam logic [3:0]  RPS_IDX_OUT0   = 4'h4;
    localparam logic [3:0]  RPS_IDX_OUT7   = 4'hb;

    localparam logic [4:0]  RPS_IN_RST     = 5'h1f;
    localparam logic [4:0]  RPS_OUT_RST    = 5'h00;
    localparam logic [4:0]  RPS_IN_OFF     = 5'h1f;
    localparam logic [4:0]  RPS_PIN_MAX    = 5'h0f;

    typedef logic [RPS_SEL_W-1:0] rps_sel_t;

    // Input selector bank, in the order of the peripheral inputs.
    typedef struct packed {
        rps_sel_t spi_slave_sel_pin_sel;
        rps_sel_t spi_data_in_pin_sel;
        rps_sel_t spi_clock_pin_sel;
        rps_sel_t uart_cts_pin_sel;
        rps_sel_t uart_rx_pin_sel;
        rps_sel_t fault_a_pin_sel;
    } rps_in_sel_s;

    // Routed peripheral inputs.
    typedef struct packed {
        logic spi_slave_sel_in;
        logic spi_data_in;
        logic spi_clock_in;
        logic uart_cts_in;
        logic uart_rx_in;
        logic compare_fault_a_in;
    } rps_periph_in_s;

    // Picks a pin by selector code; codes above the last pin hold the input low.
    function automatic logic rps_route(input logic [RPS_NUM_PINS-1:0] pins,
                                       input rps_sel_t sel);
        if (sel <= RPS_PIN_MAX) begin
            return pins[sel[3:0]];
        end
        return 1'b0;
    endfunction

endpackage

// ### design/rps_out_func_regs.sv
// Register bank of the per-pin output function selectors.
`timescale 1ns/1ps
module rps_out_func_regs
    import rps_pkg::*;
(
    // Clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    // Write port
    input  wire logic                                  we_i,
    input  wire logic [2:0]                            widx_i,
    input  wire logic [RPS_REG_W-1:0]                  wdata_i,
    // Read port
    input  wire logic [2:0]                            ridx_i,
    output logic      [RPS_REG_W-1:0]                  rdata_o,
    // Selectors of all pins
    output logic      [RPS_NUM_PINS-1:0][RPS_SEL_W-1:0] func_o
);

    logic [RPS_NUM_PINS-1:0][RPS_SEL_W-1:0] func_r;

    assign func_o = func_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_r <= {RPS_NUM_PINS{RPS_OUT_RST}};
        end else if (we_i) begin
            func_r[{widx_i, 1'b0}] <= wdata_i[RPS_LO_LSB +: RPS_SEL_W];
            func_r[{widx_i, 1'b1}] <= wdata_i[RPS_HI_LSB +: RPS_SEL_W];
        end
    end

    // Read data leaves a register; unused bits stay zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= '0;
            rdata_o[RPS_LO_LSB +: RPS_SEL_W] <= func_r[{ridx_i, 1'b0}];
            rdata_o[RPS_HI_LSB +: RPS_SEL_W] <= func_r[{ridx_i, 1'b1}];
        end
    end

endmodule

// ### design/rps_pin_select.sv
// Remappable pin select matrix with a classic Wishbone register slave.
`timescale 1ns/1ps
module rps_pin_select
    import rps_pkg::*;
(
    // Clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    // Wishbone slave
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_we_i,
    input  wire logic [RPS_ADDR_W-1:0]                 wb_adr_i,
    input  wire logic [3:0]                            wb_sel_i,
    input  wire logic [RPS_DATA_W-1:0]                 wb_dat_i,
    output logic      [RPS_DATA_W-1:0]                 wb_dat_o,
    output logic                                       wb_ack_o,
    output logic                                       wb_err_o,
    // Remappable pins
    input  wire logic [RPS_NUM_PINS-1:0]               remap_pin_i,
    // Peripheral side
    output rps_periph_in_s                             periph_in_o,
    output logic      [RPS_NUM_PINS-1:0][RPS_FUNC_W-1:0] pin_out_func_o
);

    rps_in_sel_s                            in_sel_r;
    logic                                   req;
    logic                                   ack_r;
    logic                                   err_r;
    logic [3:0]                             idx;
    logic                                   hit;
    logic                                   is_out;
    logic                                   out_we;
    logic [RPS_REG_W-1:0]                   wdata;
    logic [RPS_REG_W-1:0]                   out_rdata;
    logic [RPS_NUM_PINS-1:0][RPS_SEL_W-1:0] out_func;
    logic [RPS_DATA_W-1:0]                  in_rdata;
    logic                                   rd_from_out_r;
    logic [2:0]                             out_idx;
    logic [RPS_DATA_W-1:0]                  dat_r;

    // A new request is only seen while ack is low, so each access answers once.
    assign req    = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign idx    = wb_adr_i[RPS_ADDR_W-1:2];
    assign hit    = (idx <= RPS_IDX_OUT7);
    assign is_out = (idx >= RPS_IDX_OUT0) && hit;
    assign out_we = req && wb_we_i && is_out && (&wb_sel_i[1:0]);
    assign wdata  = wb_dat_i[RPS_REG_W-1:0];
    assign out_idx = 3'(idx - RPS_IDX_OUT0);

    // Packs the two output selectors of one register word; unused bits read as zero.
    function automatic logic [RPS_REG_W-1:0] out_word(
        input logic [RPS_NUM_PINS-1:0][RPS_SEL_W-1:0] func,
        input logic [2:0]                             widx);
        logic [RPS_REG_W-1:0] w;
        w = '0;
        w[RPS_LO_LSB +: RPS_SEL_W] = func[{widx, 1'b0}];
        w[RPS_HI_LSB +: RPS_SEL_W] = func[{widx, 1'b1}];
        return w;
    endfunction

    // Writes need both low byte lanes; a partial write leaves the fields unchanged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_sel_r <= {RPS_NUM_IN_SEL{RPS_IN_RST}};
        end else if (req && wb_we_i && (&wb_sel_i[1:0])) begin
            unique case (idx)
                RPS_IDX_FAULT: begin
                    in_sel_r.fault_a_pin_sel <= wdata[RPS_LO_LSB +: RPS_SEL_W];
                end
                RPS_IDX_UART: begin
                    in_sel_r.uart_rx_pin_sel  <= wdata[RPS_LO_LSB +: RPS_SEL_W];
                    in_sel_r.uart_cts_pin_sel <= wdata[RPS_HI_LSB +: RPS_SEL_W];
                end
                RPS_IDX_SPICD: begin
                    in_sel_r.spi_data_in_pin_sel <= wdata[RPS_LO_LSB +: RPS_SEL_W];
                    in_sel_r.spi_clock_pin_sel   <= wdata[RPS_HI_LSB +: RPS_SEL_W];
                end
                RPS_IDX_SPISS: begin
                    in_sel_r.spi_slave_sel_pin_sel <= wdata[RPS_LO_LSB +: RPS_SEL_W];
                end
                default: begin
                end
            endcase
        end
    end

    // Input selector readback, zero outside the implemented fields.
    always_comb begin
        in_rdata = '0;
        unique case (idx)
            RPS_IDX_FAULT: begin
                in_rdata[RPS_LO_LSB +: RPS_SEL_W] = in_sel_r.fault_a_pin_sel;
            end
            RPS_IDX_UART: begin
                in_rdata[RPS_LO_LSB +: RPS_SEL_W] = in_sel_r.uart_rx_pin_sel;
                in_rdata[RPS_HI_LSB +: RPS_SEL_W] = in_sel_r.uart_cts_pin_sel;
            end
            RPS_IDX_SPICD: begin
                in_rdata[RPS_LO_LSB +: RPS_SEL_W] = in_sel_r.spi_data_in_pin_sel;
                in_rdata[RPS_HI_LSB +: RPS_SEL_W] = in_sel_r.spi_clock_pin_sel;
            end
            RPS_IDX_SPISS: begin
                in_rdata[RPS_LO_LSB +: RPS_SEL_W] = in_sel_r.spi_slave_sel_pin_sel;
            end
            default: begin
            end
        endcase
    end

    rps_out_func_regs u_out_regs (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (out_we),
        .widx_i  (out_idx),
        .wdata_i (wdata),
        .ridx_i  (out_idx),
        .rdata_o (out_rdata),
        .func_o  (out_func)
    );

    // Bus answer one edge after the request; unmapped addresses raise err.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_r <= 1'b0;
        end else begin
            err_r <= req && !hit;
        end
    end

    // The read word is captured at the taking edge, so the output leaves a flip-flop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (req && hit) begin
            dat_r <= is_out ? RPS_DATA_W'(out_word(out_func, out_idx)) : in_rdata;
        end else begin
            dat_r <= '0;
        end
    end

    // Remembers which bank answered, for the readback cross-check below.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_from_out_r <= 1'b0;
        end else begin
            rd_from_out_r <= is_out;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = dat_r;

    // Peripheral inputs are registered so the outputs leave flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_in_o <= '0;
        end else begin
            periph_in_o.compare_fault_a_in <= rps_route(remap_pin_i,
                                                        in_sel_r.fault_a_pin_sel);
            periph_in_o.uart_rx_in  <= rps_route(remap_pin_i, in_sel_r.uart_rx_pin_sel);
            periph_in_o.uart_cts_in <= rps_route(remap_pin_i, in_sel_r.uart_cts_pin_sel);
            periph_in_o.spi_clock_in <= rps_route(remap_pin_i, in_sel_r.spi_clock_pin_sel);
            periph_in_o.spi_data_in <= rps_route(remap_pin_i, in_sel_r.spi_data_in_pin_sel);
            periph_in_o.spi_slave_sel_in <= rps_route(remap_pin_i,
                                                      in_sel_r.spi_slave_sel_pin_sel);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_func_o <= {RPS_NUM_PINS{RPS_OUT_RST}};
        end else begin
            pin_out_func_o <= out_func;
        end
    end

    AST_FAULT_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.fault_a_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.compare_fault_a_in == $past(remap_pin_i[in_sel_r.fault_a_pin_sel[3:0]]))
        else $error("Fault input not routed from the selected pin.");

    AST_UART_RX_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.uart_rx_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.uart_rx_in == $past(remap_pin_i[in_sel_r.uart_rx_pin_sel[3:0]]))
        else $error("Receive input not routed from the selected pin.");

    AST_IN_RESET: assert property (@(posedge clk_i)
        $past(rst_i) |-> in_sel_r == {RPS_NUM_IN_SEL{RPS_IN_RST}})
        else $error("Input selector not all ones after reset.");

    AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[RPS_DATA_W-1:RPS_HI_LSB+RPS_SEL_W] == '0
                     && wb_dat_o[RPS_HI_LSB-1:RPS_SEL_W] == '0)
        else $error("Unused read bits not zero.");

    AST_SS_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_slave_sel_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.spi_slave_sel_in ==
        $past(remap_pin_i[in_sel_r.spi_slave_sel_pin_sel[3:0]]))
        else $error("Slave select not routed from the selected pin.");

    sequence s_out_write;
        req && wb_we_i && is_out && (&wb_sel_i[1:0]);
    endsequence

    AST_OUT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_out_write ##2 1'b1 |->
        pin_out_func_o[{$past(idx - RPS_IDX_OUT0, 2), 1'b1}] ==
        $past(wdata[RPS_HI_LSB +: RPS_SEL_W], 2))
        else $error("Odd pin output selector not updated.");

    AST_OUT_RESET: assert property (@(posedge clk_i)
        $past(rst_i, 2) && $past(rst_i) |-> pin_out_func_o == '0)
        else $error("Output selectors not zero after reset.");

    AST_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.uart_cts_pin_sel == RPS_IN_OFF |=> !periph_in_o.uart_cts_in)
        else $error("Disconnected input not held low.");

    AST_ACK_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held for more than one cycle.");

    sequence s_take;
        req && hit;
    endsequence

    sequence s_fault_write;
        req && wb_we_i && (&wb_sel_i[1:0]) && (idx == RPS_IDX_FAULT);
    endsequence

    sequence s_uart_write;
        req && wb_we_i && (&wb_sel_i[1:0]) && (idx == RPS_IDX_UART);
    endsequence

    sequence s_ss_write;
        req && wb_we_i && (&wb_sel_i[1:0]) && (idx == RPS_IDX_SPISS);
    endsequence

    AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
        s_take |=> wb_ack_o && !wb_err_o)
        else $error("Mapped request not acknowledged in the next cycle.");

    AST_ERR_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("Unmapped request not answered with err.");

    AST_ERR_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_err_o |=> !wb_err_o)
        else $error("Err held for more than one cycle.");

    AST_ACK_ERR_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wb_ack_o && wb_err_o))
        else $error("Ack and err raised together.");

    AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("Read data not zero outside the ack cycle.");

    AST_IN_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        s_take ##0 (!wb_we_i && idx == RPS_IDX_FAULT) |=>
        wb_dat_o == RPS_DATA_W'($past(in_sel_r.fault_a_pin_sel)))
        else $error("Fault selector not read back.");

    AST_OUT_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && rd_from_out_r |-> wb_dat_o == RPS_DATA_W'(out_rdata))
        else $error("Output selector readback differs from the register bank.");

    // Selector writes land at the taking edge.
    AST_FAULT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fault_write |=> in_sel_r.fault_a_pin_sel == $past(wdata[RPS_LO_LSB +: RPS_SEL_W]))
        else $error("Fault selector write lost.");

    AST_UART_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_uart_write |=> in_sel_r.uart_rx_pin_sel == $past(wdata[RPS_LO_LSB +: RPS_SEL_W])
        && in_sel_r.uart_cts_pin_sel == $past(wdata[RPS_HI_LSB +: RPS_SEL_W]))
        else $error("Receive or clear-to-send selector write lost.");

    AST_SS_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ss_write |=> in_sel_r.spi_slave_sel_pin_sel == $past(wdata[RPS_LO_LSB +: RPS_SEL_W]))
        else $error("Slave select selector write lost.");

    AST_OUT_WRITE_EVEN: assert property (@(posedge clk_i) disable iff (rst_i)
        s_out_write ##2 1'b1 |->
        pin_out_func_o[{$past(out_idx, 2), 1'b0}] == $past(wdata[RPS_LO_LSB +: RPS_SEL_W], 2))
        else $error("Even pin output selector not updated.");

    AST_SEL_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
        !(req && wb_we_i && (&wb_sel_i[1:0])) |=> $stable(in_sel_r))
        else $error("Input selector changed without a full write.");

    AST_OUT_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
        !out_we |=> $stable(out_func))
        else $error("Output selector changed without a full write.");

    // Routing of the remaining peripheral inputs; disconnected inputs held low.
    AST_CTS_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.uart_cts_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.uart_cts_in == $past(remap_pin_i[in_sel_r.uart_cts_pin_sel[3:0]]))
        else $error("Clear-to-send input not routed from the selected pin.");

    AST_SPI_CLOCK_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_clock_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.spi_clock_in == $past(remap_pin_i[in_sel_r.spi_clock_pin_sel[3:0]]))
        else $error("Serial clock input not routed from the selected pin.");

    AST_SPI_DATA_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_data_in_pin_sel <= RPS_PIN_MAX |=>
        periph_in_o.spi_data_in == $past(remap_pin_i[in_sel_r.spi_data_in_pin_sel[3:0]]))
        else $error("Serial data input not routed from the selected pin.");

    AST_FAULT_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.fault_a_pin_sel > RPS_PIN_MAX |=> !periph_in_o.compare_fault_a_in)
        else $error("Disconnected fault input not held low.");

    AST_RX_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.uart_rx_pin_sel > RPS_PIN_MAX |=> !periph_in_o.uart_rx_in)
        else $error("Disconnected receive input not held low.");

    AST_SS_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_slave_sel_pin_sel > RPS_PIN_MAX |=> !periph_in_o.spi_slave_sel_in)
        else $error("Disconnected slave select input not held low.");

    AST_SPI_CLOCK_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_clock_pin_sel > RPS_PIN_MAX |=> !periph_in_o.spi_clock_in)
        else $error("Disconnected serial clock input not held low.");

    AST_SPI_DATA_OFF_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        in_sel_r.spi_data_in_pin_sel > RPS_PIN_MAX |=> !periph_in_o.spi_data_in)
        else $error("Disconnected serial data input not held low.");

endmodule

// ### tb/rps_pin_model.sv
// Pin-side partner model that drives a new level pattern on the remappable pins every cycle while load_i is low.
`timescale 1ns/1ps
module rps_pin_model (
    // Clock and load
    input  wire logic        clk_i,
    input  wire logic        load_i,
    input  wire logic [15:0] seed_i,
    // Pin levels
    output logic      [15:0] pins_o
);
    // A changing pattern keeps a stale or wrong selector from matching by chance.
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            pins_o <= seed_i;
        end else begin
            pins_o <= {pins_o[14:0], pins_o[15] ^ pins_o[13] ^ pins_o[12] ^ pins_o[10]};
        end
    end
endmodule

// ### tb/rps_pin_select_tb.sv
// Self-checking testbench of the remappable pin select block.
`timescale 1ns/1ps
module rps_pin_select_tb;
    import rps_pkg::*;
    logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, load;
    logic [5:0]           wb_adr_i;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i, wb_dat_o, rd;
    logic [15:0]          remap_pin_i, seed, mreg[12];
    rps_periph_in_s       periph_in_o;
    logic [15:0][4:0]     pin_out_func_o;
    logic                 er;
    int                   n_mismatch, comparisons;

    rps_pin_select i_rps_pin_select (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .remap_pin_i(remap_pin_i), .periph_in_o(periph_in_o), .pin_out_func_o(pin_out_func_o));
    rps_pin_model i_rps_pin_model (.clk_i(clk_i), .load_i(load), .seed_i(seed),
        .pins_o(remap_pin_i));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [15:0] fmask(input int i);
        return (i == 0 || i == 3) ? 16'h001f : 16'h1f1f;
    endfunction

    function automatic logic pick(input logic [15:0] p, input logic [4:0] s);
        return (s < 5'h10) ? p[s[3:0]] : 1'b0;
    endfunction

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_out(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic single cycle: hold everything until ack or err is sampled high.
    task automatic wb_xfer(input logic we, input int idx, input logic [15:0] d,
                           input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx[3:0], 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {16'hffff, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            print_verdict();
        end
        if (we && idx < 12 && sel[1:0] == 2'b11) begin
            mreg[idx] = d & fmask(idx);
        end
    endtask

    task automatic read_all();
        for (int i = 0; i < 16; i++) begin
            wb_xfer(1'b0, i, 16'h0, 4'hf);
            check_reg("bus_err", {31'h0, i > 11}, {31'h0, er});
            if (i < 12) begin
                check_reg("reg_read", {16'h0, mreg[i]}, rd);
            end else begin
                check_reg("err_data", 32'h0, rd);
            end
        end
        for (int p = 0; p < 16; p++) begin
            check_out("pin_func", {3'h0, p[0] ? mreg[4 + p / 2][12:8] : mreg[4 + p / 2][4:0]},
                      {3'h0, pin_out_func_o[p]});
        end
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) mreg[i] = (i < 4) ? fmask(i) : 16'h0;
    endtask

    initial begin
        logic [15:0] p;
        logic [7:0]  e;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(32'h2e5ee670));
        seed = 16'($urandom()) | 16'h0001;
        load = 1'b1;
        rst_i = 1'b1;
        do_reset();
        load <= 1'b0;
        read_all();
        for (int i = 0; i < 16; i++) wb_xfer(1'b1, i, 16'($urandom()), 4'hf);
        wb_xfer(1'b1, 5, 16'h0a0a, 4'b0101);
        read_all();
        // Round 0 selects the last pin, round 1 the first code that disconnects, round 2 all ones.
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < 4; i++) begin
                wb_xfer(1'b1, i, (r == 0) ? 16'h0f0f : (r == 1) ? 16'h1010 :
                        (r == 2) ? 16'h1f1f : 16'($urandom()), 4'hf);
            end
            repeat (20) begin
                @(negedge clk_i);
                p = remap_pin_i;
                @(posedge clk_i);
                #1;
                e = {2'b00, pick(p, mreg[3][4:0]), pick(p, mreg[2][4:0]), pick(p, mreg[2][12:8]),
                     pick(p, mreg[1][12:8]), pick(p, mreg[1][4:0]), pick(p, mreg[0][4:0])};
                check_out("periph_in", e, {2'b00, periph_in_o});
            end
        end
        @(posedge clk_i);
        do_reset();
        read_all();
        print_verdict();
    end
endmodule
